// File: verilog/uacf_pkg.sv
// uart character framing: shared constants, types and helpers
// assumes one pclk domain at 125 MHz, apb with byte addresses
//
// Notes on behaviour
// - five character modes: 7-bit, 8-bit, even parity, odd parity, address.
// - two-level nrz line, resting at mark while no character is sent.
// - frame is start, 7 or 8 data, optional ninth bit, stop.
// - start bit is space (0), stop bits are mark (1).
// - every start and data bit stays on the line for exactly one bit period.
// - bit timing comes from a 16-bit divider of the system clock.
// - data bits go out and come in least significant bit first.
// - transmitter and receiver independent but share format and baud rate.
// - changing transmit_invert changes the tx pin at once, unless the line also changes in that cycle.
// - when pin_direction_control selects output, the uart drives the pin.
// - stop period of one, one and a half or two bit periods.
// - parity modes send even or odd parity as ninth bit, check it.
// - address mode flags received characters whose ninth bit is set.
// - overrun when a character completes while the two-entry buffer is full.
// - framing error when the received stop bit is not mark.
// - serial output goes to the pin and to an internal output.
// - mode 0001 sends only the seven low bits of the byte.
// - mode 0011 is even parity, 0010 odd, parity bit generated.
// - transmit_invert 0 gives high-true levels, 1 gives low-true.

package uacf_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_BAUD   = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // status bit positions
  localparam int ST_TXB_EMPTY = 0;
  localparam int ST_TX_IDLE   = 1;
  localparam int ST_RX_AVAIL  = 2;
  localparam int ST_RX_FULL   = 3;
  localparam int ST_OVERRUN   = 4;
  localparam int ST_FRAMING   = 5;
  localparam int ST_PARITY    = 6;
  localparam int ST_ADDRESS   = 7;

  // ==========================================================
  // character modes and stop lengths
  localparam logic [3:0] MODE_8    = 4'h0;
  localparam logic [3:0] MODE_7    = 4'h1;
  localparam logic [3:0] MODE_ODD  = 4'h2;
  localparam logic [3:0] MODE_EVEN = 4'h3;
  localparam logic [3:0] MODE_ADDR = 4'h4;
  localparam logic [1:0] STOP_1    = 2'h0;
  localparam logic [1:0] STOP_15   = 2'h1;
  localparam logic [1:0] STOP_2    = 2'h2;

  // ==========================================================
  // timing: 16 baud ticks per bit
  localparam logic [4:0] TICK_LAST    = 5'h0F;
  localparam logic [4:0] TICK_MID     = 5'h07;
  localparam logic [4:0] STOP_LAST_1  = 5'h0F;
  localparam logic [4:0] STOP_LAST_15 = 5'h17;
  localparam logic [4:0] STOP_LAST_2  = 5'h1F;
  localparam logic [15:0] BAUD_RESET  = 16'h0000;

  // ==========================================================
  // types
  typedef struct packed {
    logic [1:0] stop;
    logic [3:0] mode;
    logic       pdc;    // pin_direction_control, 0 = output
    logic       txinv;  // transmit_invert
    logic       rxen;
    logic       transmit_enable;
    logic       on;
  } uacf_ctrl_t;

  localparam uacf_ctrl_t CTRL_RESET = 11'h010;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } uacf_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } uacf_apb_rsp_t;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } uacf_tx_st_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } uacf_rx_st_t;

  typedef struct packed {
    logic [15:0] cnt;
  } uacf_baud_st_t;

  // ==========================================================
  // helpers for transmit, receive and apb address decode
  function automatic logic [3:0] frame_bits(input logic [3:0] mode);
    case (mode)
      MODE_7:                       frame_bits = 4'h7;
      MODE_ODD, MODE_EVEN, MODE_ADDR: frame_bits = 4'h9;
      default:                      frame_bits = 4'h8;
    endcase
  endfunction : frame_bits

  function automatic logic par_bit(input logic [3:0] mode,
                                   input logic [7:0] data);
    par_bit = (mode == MODE_EVEN) ? ^data : ~^data;
  endfunction : par_bit

  function automatic logic [4:0] stop_last(input logic [1:0] stop);
    case (stop)
      STOP_15: stop_last = STOP_LAST_15;
      STOP_2:  stop_last = STOP_LAST_2;
      default: stop_last = STOP_LAST_1;
    endcase
  endfunction : stop_last

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ADDR_CTRL) || (a == ADDR_BAUD) ||
              (a == ADDR_TXDATA) || (a == ADDR_RXDATA) ||
              (a == ADDR_STATUS);
  endfunction : addr_ok

endpackage : uacf_pkg

// File: verilog/uacf_baud.sv
// baud tick divider: one tick per (div + 1) enabled clocks
// assumes the caller counts 16 ticks per bit

`timescale 1ns/1ps

module uacf_baud
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // control
  input  wire logic        run,
  input  wire logic [15:0] div,
  // tick out
  output logic             tick
);
  import uacf_pkg::*;

  uacf_baud_st_t s_q;
  uacf_baud_st_t s_d;

  // ==========================================================
  // 16-bit up-counting divider of the system clock
  always_comb
  begin
    tick  = run & (s_q.cnt == div);
    s_d   = s_q;
    if (!run || tick)
      s_d.cnt = 16'h0000;
    else
      s_d.cnt = s_q.cnt + 16'h0001;
  end

  // state register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else if (ce)
      s_q <= s_d;
  end

endmodule : uacf_baud

// File: verilog/uacf_uart.sv
// uart character framing top: apb registers, transmitter, receiver
// assumes rx_i synchronous to pclk and apb master per amba rules

`timescale 1ns/1ps

module uacf_uart
(
  // clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           ce,
  // apb slave
  input  uacf_pkg::uacf_apb_req_t apb_req,
  output uacf_pkg::uacf_apb_rsp_t apb_rsp,
  // serial pins
  input  wire logic           rx_i,
  output logic                tx_o,
  output logic                tx_oe,
  output logic                tx_int_o
);
  import uacf_pkg::*;

  // ==========================================================
  // whole-block state
  typedef struct packed {
    uacf_ctrl_t        ctrl;
    logic [15:0]       baud;
    logic [31:0]       prdata;
    logic              slverr;
    logic              txb_v;
    logic [8:0]        txb;
    uacf_tx_st_t       tst;
    logic [8:0]        tsr;
    logic [4:0]        tcnt;
    logic [3:0]        tbit;
    logic              line;
    uacf_rx_st_t       rst;
    logic [8:0]        rsr;
    logic [4:0]        rcnt;
    logic [3:0]        rbit;
    logic [1:0][10:0]  fifo;
    logic [1:0]        fcnt;
    logic              ovr;
    logic              fer;
    logic              per;
    logic              adr;
  } uacf_state_t;

  uacf_state_t s_q;
  uacf_state_t s_d;

  logic        tick;
  logic        wr;
  logic        rd;
  logic        pop;
  logic        push;
  logic        tx_run;
  logic        rx_run;
  logic [3:0]  fbits;
  logic [8:0]  frame;
  logic [10:0] entry;
  logic [7:0]  status;

  // ==========================================================
  // one shared tick for both directions
  uacf_baud u_baud
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .run     (s_q.ctrl.on),
    .div     (s_q.baud),
    .tick    (tick)
  );

  // ==========================================================
  // pin outputs
  assign tx_o     = s_q.line ^ s_q.ctrl.txinv;
  assign tx_int_o = tx_o;
  assign tx_oe    = ~s_q.ctrl.pdc |
                    (tx_run & (s_q.tst != TX_IDLE));
  assign apb_rsp  = '{prdata: s_q.prdata, pready: ce,
                      pslverr: s_q.slverr};

  // status word
  assign status = {s_q.adr, s_q.per, s_q.fer, s_q.ovr,
                   s_q.fcnt == 2'h2, s_q.fcnt != 2'h0,
                   (s_q.tst == TX_IDLE) & ~s_q.txb_v, ~s_q.txb_v};

  // ==========================================================
  // next-state logic
  always_comb
  begin
    s_d    = s_q;
    wr     = apb_req.psel & apb_req.penable & apb_req.pwrite;
    rd     = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
    pop    = 1'b0;
    push   = 1'b0;
    tx_run = s_q.ctrl.on & s_q.ctrl.transmit_enable;
    rx_run = s_q.ctrl.on & s_q.ctrl.rxen;
    fbits  = frame_bits(s_q.ctrl.mode);
    entry  = '0;

    // frame to send: mask top bit or add ninth bit
    frame = {1'b0, s_q.txb[7:0]};
    if (s_q.ctrl.mode == MODE_7)
      frame = {2'b00, s_q.txb[6:0]};
    else if (s_q.ctrl.mode == MODE_ADDR)
      frame = s_q.txb;
    else if (s_q.ctrl.mode == MODE_ODD ||
             s_q.ctrl.mode == MODE_EVEN)
      frame = {par_bit(s_q.ctrl.mode, s_q.txb[7:0]),
               s_q.txb[7:0]};

    // apb setup phase: latch read data and error
    if (apb_req.psel && !apb_req.penable)
    begin
      s_d.slverr = ~addr_ok(apb_req.paddr);
      case (apb_req.paddr)
        ADDR_CTRL:   s_d.prdata = {21'h0, s_q.ctrl};
        ADDR_BAUD:   s_d.prdata = {16'h0, s_q.baud};
        ADDR_RXDATA: s_d.prdata = (s_q.fcnt != 2'h0) ?
                                  {21'h0, s_q.fifo[0]} : 32'h0;
        ADDR_STATUS: s_d.prdata = {24'h0, status};
        default:     s_d.prdata = 32'h0;
      endcase
    end

    // apb access phase writes; clears come before sets
    if (wr)
    begin
      case (apb_req.paddr)
        ADDR_CTRL: s_d.ctrl = apb_req.pwdata[10:0];
        ADDR_BAUD: s_d.baud = apb_req.pwdata[15:0];
        ADDR_TXDATA:
          if (!s_q.txb_v)
          begin
            s_d.txb   = apb_req.pwdata[8:0];
            s_d.txb_v = 1'b1;
          end
        ADDR_STATUS:
        begin
          if (apb_req.pwdata[ST_OVERRUN]) s_d.ovr = 1'b0;
          if (apb_req.pwdata[ST_FRAMING]) s_d.fer = 1'b0;
          if (apb_req.pwdata[ST_PARITY])  s_d.per = 1'b0;
          if (apb_req.pwdata[ST_ADDRESS]) s_d.adr = 1'b0;
        end
        default: ;
      endcase
    end
    if (rd && apb_req.paddr == ADDR_RXDATA && s_q.fcnt != 2'h0)
      pop = 1'b1;

    // ========================================================
    // transmitter
    if (!tx_run)
    begin
      s_d.tst  = TX_IDLE;
      s_d.line = 1'b1;
    end
    else if (tick)
    begin
      unique case (s_q.tst)
        TX_IDLE:
          if (s_q.txb_v)
          begin
            s_d.tsr   = frame;
            s_d.txb_v = 1'b0;
            s_d.tst   = TX_START;
            s_d.line  = 1'b0;
            s_d.tcnt  = 5'h00;
          end
        TX_START:
          if (s_q.tcnt == TICK_LAST)
          begin
            s_d.tcnt = 5'h00;
            s_d.tbit = 4'h0;
            s_d.tst  = TX_DATA;
            s_d.line = s_q.tsr[0];
          end
          else
            s_d.tcnt = s_q.tcnt + 5'h01;
        TX_DATA:
          if (s_q.tcnt == TICK_LAST)
          begin
            s_d.tcnt = 5'h00;
            if (s_q.tbit == fbits - 4'h1)
            begin
              s_d.tst  = TX_STOP;
              s_d.line = 1'b1;
            end
            else
            begin
              s_d.tbit = s_q.tbit + 4'h1;
              s_d.line = s_q.tsr[s_q.tbit + 4'h1];
            end
          end
          else
            s_d.tcnt = s_q.tcnt + 5'h01;
        TX_STOP:
          if (s_q.tcnt == stop_last(s_q.ctrl.stop))
          begin
            s_d.tcnt = 5'h00;
            if (s_q.txb_v)
            begin
              s_d.tsr   = frame;
              s_d.txb_v = 1'b0;
              s_d.tst   = TX_START;
              s_d.line  = 1'b0;
            end
            else
              s_d.tst = TX_IDLE;
          end
          else
            s_d.tcnt = s_q.tcnt + 5'h01;
      endcase
    end

    // ========================================================
    // receiver, sampling mid-bit
    if (!rx_run)
      s_d.rst = RX_IDLE;
    else if (tick)
    begin
      unique case (s_q.rst)
        RX_IDLE:
          if (!rx_i)
          begin
            s_d.rst  = RX_START;
            s_d.rcnt = 5'h00;
            s_d.rsr  = 9'h000;
          end
        RX_START:
          if (s_q.rcnt == TICK_MID)
          begin
            s_d.rcnt = 5'h00;
            s_d.rbit = 4'h0;
            s_d.rst  = rx_i ? RX_IDLE : RX_DATA;
          end
          else
            s_d.rcnt = s_q.rcnt + 5'h01;
        RX_DATA:
          if (s_q.rcnt == TICK_LAST)
          begin
            s_d.rcnt = 5'h00;
            s_d.rsr[s_q.rbit] = rx_i;
            if (s_q.rbit == fbits - 4'h1)
              s_d.rst = RX_STOP;
            else
              s_d.rbit = s_q.rbit + 4'h1;
          end
          else
            s_d.rcnt = s_q.rcnt + 5'h01;
        RX_STOP:
          if (s_q.rcnt == TICK_LAST)
          begin
            push    = 1'b1;
            s_d.rst = RX_IDLE;
          end
          else
            s_d.rcnt = s_q.rcnt + 5'h01;
      endcase
    end

    // received entry: parity err, framing err, ninth, data
    entry[9]   = ~rx_i;
    entry[7:0] = (s_q.ctrl.mode == MODE_7) ?
                 {1'b0, s_q.rsr[6:0]} : s_q.rsr[7:0];
    if (fbits == 4'h9)
      entry[8] = s_q.rsr[8];
    if (s_q.ctrl.mode == MODE_ODD || s_q.ctrl.mode == MODE_EVEN)
      entry[10] = s_q.rsr[8] !=
                  par_bit(s_q.ctrl.mode, s_q.rsr[7:0]);

    // two-entry receive buffer; events win over clears
    if (pop)
    begin
      s_d.fifo[0] = s_q.fifo[1];
      s_d.fcnt    = s_q.fcnt - 2'h1;
    end
    if (push)
    begin
      if (s_d.fcnt == 2'h2)
        s_d.ovr = 1'b1;
      else
      begin
        s_d.fifo[s_d.fcnt[0]] = entry;
        s_d.fcnt = s_d.fcnt + 2'h1;
      end
      if (entry[9])
        s_d.fer = 1'b1;
      if (entry[10])
        s_d.per = 1'b1;
      if (s_q.ctrl.mode == MODE_ADDR && entry[8])
        s_d.adr = 1'b1;
    end
  end

  // ==========================================================
  // state register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q       <= '0;
      s_q.ctrl  <= CTRL_RESET;
      s_q.baud  <= BAUD_RESET;
      s_q.tst   <= TX_IDLE;
      s_q.rst   <= RX_IDLE;
      s_q.line  <= 1'b1;
    end
    else if (ce)
      s_q <= s_d;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_idle_mark: assert property (
    s_q.tst == TX_IDLE |-> s_q.line)
    else $error("line not at mark while idle");

  a_start_space: assert property (
    s_q.tst == TX_START |-> !s_q.line)
    else $error("start bit not space");

  a_stop_mark: assert property (
    s_q.tst == TX_STOP |-> s_q.line)
    else $error("stop bit not mark");

  a_invert_now: assert property (
    ce && $changed(s_q.ctrl.txinv) && $stable(s_q.line)
    |-> tx_o != $past(tx_o))
    else $error("invert did not flip pin at once");

  a_lsb_first: assert property (
    s_q.tst == TX_DATA && $past(s_q.tst) == TX_START
    |-> s_q.line == s_q.tsr[0])
    else $error("first data bit is not bit 0");

  a_bit_hold: assert property (
    s_q.tst == TX_DATA && $changed(s_q.tbit)
    |-> $past(s_q.tcnt) == TICK_LAST)
    else $error("data bit not held 16 ticks");

  a_even_parity: assert property (
    s_q.tst == TX_DATA && s_q.tbit == 4'h8 &&
    s_q.ctrl.mode == MODE_EVEN |-> s_q.line == ^s_q.tsr[7:0])
    else $error("even parity bit wrong");

  a_seven_only: assert property (
    s_q.ctrl.mode == MODE_7 && s_q.tst == TX_DATA
    |-> s_q.tbit < 4'h7 && !s_q.tsr[7])
    else $error("seven-bit mode sends top bit");

  a_overrun_set: assert property (
    ce && push && s_q.fcnt == 2'h2 && !pop |=> s_q.ovr)
    else $error("overrun not flagged");

  a_framing_set: assert property (
    ce && push && !rx_i |=> s_q.fer && s_q.fcnt != 2'h0)
    else $error("framing error not flagged");

  a_pin_own: assert property (
    !s_q.ctrl.pdc |-> tx_oe)
    else $error("tx pin released while output");

  a_fifo_depth: assert property (
    s_q.fcnt <= 2'h2)
    else $error("receive buffer over two");

  c_back_to_back: cover property (
    s_q.tst == TX_STOP ##1 s_q.tst == TX_START);
  c_parity_frame: cover property (
    s_q.tst == TX_DATA && s_q.tbit == 4'h8);
  c_overrun: cover property (ce && push && s_q.fcnt == 2'h2);
  c_framing: cover property (ce && push && !rx_i);

endmodule : uacf_uart

// File: tb/uacf_remote.sv
// remote serial node: sends frames into the uart receive line and
// decodes frames seen on the uart transmit output
// assumes 16 pclk per bit (divisor 0) and mark-idle nrz levels

`timescale 1ns/1ps

module uacf_remote
#(
  parameter int BIT = 16
)
(
  // clock
  input  wire logic       pclk,
  // line from the uart, its polarity and decoder enable
  input  wire logic       line_i,
  input  wire logic       inv_i,
  input  wire logic       en_i,
  input  wire logic [3:0] nbits_i,
  // line into the uart
  output logic            rx_o
);
  // ==========================================================
  // decoded frame store
  logic [8:0] word = '0;
  logic       stop_seen = 1'b0;
  int         frames = 0;
  realtime    t_prev = 0.0;
  realtime    t_last = 0.0;
  logic       lvl;

  // undo the uart polarity before decoding
  assign lvl = line_i ^ inv_i;
  initial rx_o = 1'b1;

  // decode one frame after each start edge, sampling mid-bit
  always
  begin
    @(posedge pclk iff (en_i && lvl === 1'b0));
    t_prev = t_last;
    t_last = $realtime;
    word   = '0;
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < int'(nbits_i); i++)
    begin
      repeat (BIT) @(posedge pclk);
      word[i] = lvl;
    end
    repeat (BIT) @(posedge pclk);
    stop_seen = lvl;
    frames++;
  end

  // ==========================================================
  // send one frame; a stop of space is cut short so that a start
  // seen in its tail finds mark at mid-start and is dropped
  task automatic send(input logic [8:0] d, input int nb,
                      input logic stop_v);
    rx_o <= 1'b0;
    repeat (BIT) @(posedge pclk);
    for (int i = 0; i < nb; i++)
    begin
      rx_o <= d[i];
      repeat (BIT) @(posedge pclk);
    end
    rx_o <= stop_v;
    repeat (stop_v ? BIT : BIT / 2 + 4) @(posedge pclk);
    rx_o <= 1'b1;
    repeat (2 * BIT) @(posedge pclk);
  endtask : send

endmodule : uacf_remote

// File: tb/tb_top.sv
// testbench for the uart framing block: apb tasks, tx and rx frames
// assumes divisor 0 (16 pclk per bit) and the remote node model

`timescale 1ns/1ps

module tb_top;
  import uacf_pkg::*;

  // ==========================================================
  // clock, reset and wiring
  logic          pclk       = 1'b0;
  logic          presetn    = 1'b0;
  logic          ce         = 1'b1;
  uacf_apb_req_t apb_req    = '0;
  uacf_apb_rsp_t apb_rsp;
  logic          rx_line;
  logic          tx_o;
  logic          tx_oe;
  logic          tx_int_o;
  logic          inv        = 1'b0;
  logic          mon_en     = 1'b0;
  logic [3:0]    nbits      = 4'h8;
  int            mismatches = 0;
  int            compares   = 0;
  int            cycles     = 0;
  logic [31:0]   rd;
  logic          err;
  logic [3:0]    tx_mode [5] = '{MODE_8, MODE_7, MODE_ODD, MODE_EVEN,
                                 MODE_ADDR};
  logic [8:0]    tx_dat  [5] = '{9'h0A5, 9'h0B5, 9'h0A5, 9'h0B5, 9'h1A5};
  logic [8:0]    tx_exp  [5] = '{9'h0A5, 9'h035, 9'h1A5, 9'h1B5, 9'h1A5};
  logic [3:0]    tx_nb   [5] = '{4'h8, 4'h7, 4'h9, 4'h9, 4'h9};
  logic [3:0]    rx_mode [6] = '{MODE_EVEN, MODE_EVEN, MODE_8, MODE_ADDR,
                                 MODE_7, MODE_ODD};
  logic [8:0]    rx_d    [6] = '{9'h1B5, 9'h0B5, 9'h03C, 9'h142, 9'h05A,
                                 9'h1A5};
  int            rx_nb   [6] = '{9, 9, 8, 9, 7, 9};
  logic          rx_stop [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [31:0]   rx_exp  [6] = '{32'h0B5, 32'h4B5, 32'h23C, 32'h142,
                                 32'h05A, 32'h0A5};
  logic [31:0]   rx_st   [6] = '{32'h00, 32'h40, 32'h20, 32'h80, 32'h00,
                                 32'h00};

  // 125 MHz clock
  always #4 pclk = ~pclk;

  uacf_uart dut
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .apb_req  (apb_req),
    .apb_rsp  (apb_rsp),
    .rx_i     (rx_line),
    .tx_o     (tx_o),
    .tx_oe    (tx_oe),
    .tx_int_o (tx_int_o)
  );

  uacf_remote remote
  (
    .pclk    (pclk),
    .line_i  (tx_int_o),
    .inv_i   (inv),
    .en_i    (mon_en),
    .nbits_i (nbits),
    .rx_o    (rx_line)
  );

  // ==========================================================
  // helpers
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one apb transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    apb_req.paddr   <= a;
    apb_req.pwrite  <= wr;
    apb_req.pwdata  <= wd;
    apb_req.psel    <= 1'b1;
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, exp, rd & mask);
  endtask : rdc

  task automatic wait_frames(input int n);
    int lim;
    lim = 0;
    while (remote.frames < n && lim < 2000)
    begin
      @(posedge pclk);
      lim++;
    end
    // a frame that never comes counts as a mismatch
    if (remote.frames < n)
    begin
      mismatches++;
      $display("wrong value frames expected %0d seen %0d", n,
               remote.frames);
    end
  endtask : wait_frames

  // control word: on, transmit_enable, rx enable, pin driven
  function automatic logic [31:0] ctl(input logic [3:0] m,
                                      input logic [1:0] s,
                                      input logic i);
    ctl = {21'h0, s, m, 1'b0, i, 3'b111};
  endfunction : ctl

  // ==========================================================
  // cut a hang short
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end

  // main sequence
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("tx_o reset", 32'h1, {31'h0, tx_o});
    check("tx_oe reset", 32'h0, {31'h0, tx_oe});
    rdc("ctrl reset", ADDR_CTRL, 32'hFFFFFFFF, 32'h010);
    rdc("status reset", ADDR_STATUS, 32'hFFFFFFFF, 32'h3);
    apb(1'b1, ADDR_BAUD, 32'h0000FFFF);
    rdc("baud width", ADDR_BAUD, 32'hFFFFFFFF, 32'h0000FFFF);
    apb(1'b1, ADDR_BAUD, 32'h0);
    rdc("unmapped", 8'h14, 32'hFFFFFFFF, 32'h0);
    check("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, ADDR_CTRL, 32'h018);
    check("invert idle", 32'h0, {31'h0, tx_o});
    check("internal copy", 32'h0, {31'h0, tx_int_o});
    apb(1'b1, ADDR_CTRL, 32'h008);
    check("pin owned", 32'h1, {31'h0, tx_oe});
    // every transmit mode, one of them inverted
    for (int k = 0; k < 5; k++)
    begin
      mon_en = 1'b0;
      inv    = (k == 2);
      apb(1'b1, ADDR_CTRL, ctl(tx_mode[k], STOP_1, inv));
      nbits  = tx_nb[k];
      mon_en = 1'b1;
      apb(1'b1, ADDR_TXDATA, {23'h0, tx_dat[k]});
      wait_frames(k + 1);
      check("tx frame", {23'h0, tx_exp[k]},
            {23'h0, remote.word});
      check("tx stop", 32'h1, {31'h0, remote.stop_seen});
    end
    // back-to-back frames for each stop length
    nbits = 4'h8;
    for (int s = 0; s < 3; s++)
    begin
      apb(1'b1, ADDR_CTRL, ctl(MODE_8, s[1:0], 1'b0) | 32'h10);
      apb(1'b1, ADDR_TXDATA, 32'h55);
      apb(1'b1, ADDR_TXDATA, 32'hAA);
      check("tx_oe busy", 32'h1, {31'h0, tx_oe});
      wait_frames(7 + 2 * s);
      check("frame gap", 32'(160 + 8 * s), 32'(int'(
            (remote.t_last - remote.t_prev) / 8.0)));
      check("second frame", 32'hAA, {23'h0, remote.word});
      repeat (40) @(posedge pclk);
      check("tx idle", 32'h1, {31'h0, tx_o & ~tx_oe});
    end
    // receive modes with parity, framing and address cases
    for (int k = 0; k < 6; k++)
    begin
      apb(1'b1, ADDR_CTRL, ctl(rx_mode[k], STOP_1, 1'b0));
      remote.send(rx_d[k], rx_nb[k], rx_stop[k]);
      rdc("rx data", ADDR_RXDATA, (rx_mode[k] == MODE_ADDR) ?
          32'h7FF : 32'h6FF, rx_exp[k]);
      rdc("rx flags", ADDR_STATUS, 32'hF0, rx_st[k]);
      apb(1'b1, ADDR_STATUS, 32'hF0);
    end
    // overrun while the transmitter runs on its own
    apb(1'b1, ADDR_CTRL, ctl(MODE_8, STOP_1, 1'b0));
    apb(1'b1, ADDR_TXDATA, 32'hC3);
    remote.send(9'h011, 8, 1'b1);
    remote.send(9'h022, 8, 1'b1);
    remote.send(9'h033, 8, 1'b1);
    check("tx beside rx", 32'hC3, {23'h0, remote.word});
    rdc("rx overrun", ADDR_STATUS, 32'h1C, 32'h1C);
    rdc("rx first", ADDR_RXDATA, 32'h7FF, 32'h011);
    rdc("rx second", ADDR_RXDATA, 32'h7FF, 32'h022);
    rdc("rx empty", ADDR_RXDATA, 32'hFFFFFFFF, 32'h0);
    finish_test();
  end

endmodule : tb_top
